// *** hdl/epso_pkg.sv ***
package epso_pkg;
	// widths of power values, minute counters, activation counter, bus address
	localparam int unsigned PW = 20;
	localparam int unsigned TW = 11;
	localparam int unsigned CW = 8;
	localparam int unsigned AW = 8;

	// timing base
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned MINUTE_S = 60;
	localparam int unsigned CYC_PER_MIN_DEF = CLK_HZ * MINUTE_S;
	localparam int unsigned DAY_MINUTES = 1440;
	localparam int unsigned DARK_HOURS = 3;
	localparam logic [TW-1:0] DARK_MINUTES = TW'(DARK_HOURS * MINUTE_S);

	// legal setting ranges
	localparam logic [PW-1:0] PWR_MIN = 20'h0_0001;
	localparam logic [PW-1:0] PWR_MAX = 20'hF_3E58;
	localparam logic [TW-1:0] T_MIN = 11'h001;
	localparam logic [TW-1:0] QUAL_MAX = 11'h2D0;
	localparam logic [TW-1:0] RUN_MAX = 11'h5A0;
	localparam logic [TW-1:0] HP_DUTY_MIN = 11'h00A;
	localparam logic [CW-1:0] TA_MAX = 8'hFF;

	// heat-pump operating states presented on hp_state
	localparam logic [1:0] HP_NORMAL = 2'h2;
	localparam logic [1:0] HP_BOOST = 2'h3;

	// register byte offsets
	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_ACT = 8'h04;
	localparam logic [AW-1:0] OFS_DEACT = 8'h08;
	localparam logic [AW-1:0] OFS_T1 = 8'h0C;
	localparam logic [AW-1:0] OFS_T2 = 8'h10;
	localparam logic [AW-1:0] OFS_TA = 8'h14;
	localparam logic [AW-1:0] OFS_HPQ = 8'h18;
	localparam logic [AW-1:0] OFS_STAT = 8'h1C;

	// control register fields
	localparam int unsigned CTRL_W = 6;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CTRL_SRC_BIT = 3;
	localparam int unsigned CTRL_NC_BIT = 4;
	localparam int unsigned CTRL_HOLD_BIT = 5;

	// status register fields
	localparam int unsigned STAT_ACT_BIT = 0;
	localparam int unsigned STAT_CONTACT_BIT = 1;
	localparam int unsigned STAT_HP_LSB = 2;
	localparam int unsigned STAT_STATE_LSB = 4;
	localparam int unsigned STAT_CNT_LSB = 8;

	// reset values
	localparam logic [CTRL_W-1:0] RST_CTRL = 6'h00;
	localparam logic [PW-1:0] RST_ACT = 20'h0_03E8;
	localparam logic [PW-1:0] RST_DEACT = 20'h0_02BC;
	localparam logic [TW-1:0] RST_T1 = 11'h001;
	localparam logic [TW-1:0] RST_T2 = 11'h00A;
	localparam logic [CW-1:0] RST_TA = 8'h01;
	localparam logic [TW-1:0] RST_HPQ = 11'h00A;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_OFF, MODE_TIMED, MODE_HYST, MODE_HEAT} epso_mode_t;
	typedef enum logic [2:0] {S_IDLE, S_QUAL, S_RUN, S_PAUSE, S_ON, S_HOLD} epso_state_t;
endpackage

// *** hdl/epso_evt_if.sv ***
interface epso_evt_if;
	logic tick_min;
	logic tick_day;
	logic above_act;
	logic below_deact;
	modport tick_src (output tick_min, output tick_day);
	modport cmp_src (output above_act, output below_deact);
	modport ctrl (input tick_min, input tick_day, input above_act, input below_deact);
endinterface

// *** hdl/epso_tick.sv ***
module epso_tick #(
	parameter int unsigned CYC_PER_MIN = epso_pkg::CYC_PER_MIN_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	epso_evt_if.tick_src ev
);
	import epso_pkg::*;
	logic [31:0] pre_q;
	logic [TW-1:0] mday_q;
	logic tmin_q;
	logic tday_q;

	// minute prescaler and minute-of-day counter, one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= 32'h0000_0000;
			mday_q <= '0;
			tmin_q <= 1'b0;
			tday_q <= 1'b0;
		end else begin
			tmin_q <= 1'b0;
			tday_q <= 1'b0;
			if (pre_q == CYC_PER_MIN - 1) begin
				pre_q <= 32'h0000_0000;
				tmin_q <= 1'b1;
				if (mday_q == TW'(DAY_MINUTES - 1)) begin
					mday_q <= '0;
					tday_q <= 1'b1; // day boundary
				end else begin
					mday_q <= mday_q + 11'h001;
				end
			end else begin
				pre_q <= pre_q + 32'h0000_0001;
			end
		end
	end

	assign ev.tick_min = tmin_q;
	assign ev.tick_day = tday_q;
endmodule

// *** hdl/epso_cmp.sv ***
module epso_cmp #(
	parameter int unsigned W = epso_pkg::PW
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic src_pv,
	input wire logic [W-1:0] grid_excess_w,
	input wire logic [W-1:0] pv_power_w,
	input wire logic [W-1:0] act_limit,
	input wire logic [W-1:0] deact_limit,
	epso_evt_if.cmp_src ev
);
	import epso_pkg::*;
	logic [W-1:0] sel;
	logic above_q;
	logic below_q;

	// measurement basis: grid excess or pv generation
	assign sel = src_pv ? pv_power_w : grid_excess_w;

	// registered limit comparisons
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			above_q <= 1'b0;
			below_q <= 1'b1;
		end else begin
			above_q <= sel >= act_limit;
			below_q <= sel < deact_limit;
		end
	end

	assign ev.above_act = above_q;
	assign ev.below_deact = below_q;
endmodule

// *** hdl/epso_top.sv ***
// What this block does
// - timed mode: power threshold settable from 1 W to 999000 W, must be reached
// - timed mode: power must stay above threshold 1..720 minutes before switching on
// - timed mode: output then held on for run time 1..1440 minutes, then ends
// - timed run is cut off, output released, when the inverter shuts off
// - after three hours without current the remaining run time is dropped for good
// - activations counted per day; new ones only while within the daily allowance
// - after a timed interval ends, qualification re-arms if allowance remains
// - hysteresis mode: contact closes once power reaches the activation limit
// - hysteresis mode: consumer switched off when power drops below deactivation limit
// - hysteresis mode: with hold-over on, loss, fault or low power ends activation after delay
// - hysteresis mode: a fault or loss shorter than the hold-over delay keeps the output on
// - comparisons use either grid excess power or pv generation power
// - heat-pump mode: on and off conditions must persist set minutes first
// - heat-pump mode: output stays on at least the minimum duty time
// - heat-pump minimum duty below 10 minutes is refused
// - heat-pump mode: active output means state 3, inactive means state 2
// - contact polarity per output: normally open or normally closed
module epso_top #(
	parameter int unsigned CYC_PER_MIN = epso_pkg::CYC_PER_MIN_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [epso_pkg::AW-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [epso_pkg::AW-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic [epso_pkg::PW-1:0] grid_excess_w,
	input wire logic [epso_pkg::PW-1:0] pv_power_w,
	input wire logic inverter_on,
	input wire logic fault_present,
	input wire logic current_flowing,
	output logic switched_output_one,
	output logic [1:0] hp_state
);
	import epso_pkg::*;

	epso_evt_if ev ();

	logic [CTRL_W-1:0] ctrl_q;
	logic [PW-1:0] activation_power_limit_q;
	logic [PW-1:0] deactivation_power_limit_q;
	logic [TW-1:0] qualify_or_holdover_minutes_q;
	logic [TW-1:0] run_time_minutes_q;
	logic [CW-1:0] activations_per_day_q;
	logic [TW-1:0] hp_persist_q;
	logic aw_v_q;
	logic [AW-1:0] aw_a_q;
	logic w_v_q;
	logic [31:0] w_d_q;
	logic [3:0] w_s_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_wr;
	logic wr_good;
	logic cfg_wr;
	logic [31:0] wr_val;
	epso_state_t state_q;
	epso_state_t state_d;
	logic [TW-1:0] min_q;
	logic [TW-1:0] min_d;
	logic [TW-1:0] off_q;
	logic [TW-1:0] dark_q;
	logic [CW-1:0] count_q;
	logic act_evt;
	logic contact_q;
	logic [1:0] hp_q;
	logic en;
	epso_mode_t mode;
	logic nc;
	logic hold_en;
	logic healthy;
	logic cap_ok;
	logic start_ok;
	logic [TW-1:0] duty;
	logic [TW-1:0] qual_target;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// current stored value at an offset, zero-extended
	function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
		case (a)
			OFS_CTRL: rd_word = 32'(ctrl_q);
			OFS_ACT: rd_word = 32'(activation_power_limit_q);
			OFS_DEACT: rd_word = 32'(deactivation_power_limit_q);
			OFS_T1: rd_word = 32'(qualify_or_holdover_minutes_q);
			OFS_T2: rd_word = 32'(run_time_minutes_q);
			OFS_TA: rd_word = 32'(activations_per_day_q);
			OFS_HPQ: rd_word = 32'(hp_persist_q);
			OFS_STAT: begin
				rd_word = 32'h0000_0000;
				rd_word[STAT_ACT_BIT] = contact_q ^ nc;
				rd_word[STAT_CONTACT_BIT] = contact_q;
				rd_word[STAT_HP_LSB +: 2] = hp_q;
				rd_word[STAT_STATE_LSB +: 3] = state_q;
				rd_word[STAT_CNT_LSB +: CW] = count_q;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	endfunction

	// range check of a merged write value; out-of-range values are refused
	function automatic logic wr_ok(input logic [AW-1:0] a, input logic [31:0] v,
		input epso_mode_t m);
		case (a)
			OFS_CTRL: wr_ok = 1'b1;
			OFS_ACT: wr_ok = v >= 32'(PWR_MIN) && v <= 32'(PWR_MAX);
			OFS_DEACT: wr_ok = v <= 32'(PWR_MAX);
			OFS_T1: wr_ok = v >= 32'(T_MIN) && v <= 32'(QUAL_MAX);
			OFS_T2: wr_ok = v >= 32'(m == MODE_HEAT ? HP_DUTY_MIN : T_MIN)
				&& v <= 32'(RUN_MAX);
			OFS_TA: wr_ok = v <= 32'(TA_MAX);
			OFS_HPQ: wr_ok = v >= 32'(T_MIN) && v <= 32'(RUN_MAX);
			default: wr_ok = 1'b0;
		endcase
	endfunction

	epso_tick #(.CYC_PER_MIN(CYC_PER_MIN)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.ev(ev.tick_src)
	);

	epso_cmp #(.W(PW)) u_cmp (
		.aclk(aclk),
		.aresetn(aresetn),
		.src_pv(ctrl_q[CTRL_SRC_BIT]),
		.grid_excess_w(grid_excess_w),
		.pv_power_w(pv_power_w),
		.act_limit(activation_power_limit_q),
		.deact_limit(deactivation_power_limit_q),
		.ev(ev.cmp_src)
	);

	// bus handshakes and write decode
	assign s_axil_awready = !aw_v_q && !bvalid_q;
	assign s_axil_wready = !w_v_q && !bvalid_q;
	assign s_axil_arready = !rvalid_q;
	assign s_axil_bvalid = bvalid_q;
	assign s_axil_bresp = bresp_q;
	assign s_axil_rvalid = rvalid_q;
	assign s_axil_rdata = rdata_q;
	assign s_axil_rresp = rresp_q;
	assign do_wr = aw_v_q && w_v_q && !bvalid_q;
	// merged write value and its range check; always_comb also follows the stored words
	always_comb begin
		wr_val = merge(rd_word(aw_a_q), w_d_q, w_s_q);
		wr_good = wr_ok(aw_a_q, wr_val, mode);
	end
	assign cfg_wr = do_wr && wr_good && aw_a_q == OFS_CTRL;

	// write address and data capture, in either order, then response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_v_q <= 1'b0;
			aw_a_q <= '0;
			w_v_q <= 1'b0;
			w_d_q <= 32'h0000_0000;
			w_s_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axil_awvalid && s_axil_awready) begin
				aw_v_q <= 1'b1;
				aw_a_q <= {s_axil_awaddr[AW-1:2], 2'b00};
			end
			if (s_axil_wvalid && s_axil_wready) begin
				w_v_q <= 1'b1;
				w_d_q <= s_axil_wdata;
				w_s_q <= s_axil_wstrb;
			end
			if (do_wr) begin
				aw_v_q <= 1'b0;
				w_v_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_good ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axil_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel, one registered answer per address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (s_axil_arvalid && s_axil_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word({s_axil_araddr[AW-1:2], 2'b00});
			rresp_q <= (s_axil_araddr[AW-1:2] <= OFS_STAT[AW-1:2]) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axil_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= RST_CTRL;
			activation_power_limit_q <= RST_ACT;
			deactivation_power_limit_q <= RST_DEACT;
			qualify_or_holdover_minutes_q <= RST_T1;
			run_time_minutes_q <= RST_T2;
			activations_per_day_q <= RST_TA;
			hp_persist_q <= RST_HPQ;
		end else if (do_wr && wr_good) begin
			case (aw_a_q)
				OFS_CTRL: ctrl_q <= wr_val[CTRL_W-1:0];
				OFS_ACT: activation_power_limit_q <= wr_val[PW-1:0];
				OFS_DEACT: deactivation_power_limit_q <= wr_val[PW-1:0];
				OFS_T1: qualify_or_holdover_minutes_q <= wr_val[TW-1:0];
				OFS_T2: run_time_minutes_q <= wr_val[TW-1:0];
				OFS_TA: activations_per_day_q <= wr_val[CW-1:0];
				OFS_HPQ: hp_persist_q <= wr_val[TW-1:0];
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// decoded control and shared conditions
	assign en = ctrl_q[CTRL_EN_BIT];
	assign mode = epso_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign nc = ctrl_q[CTRL_NC_BIT];
	assign hold_en = ctrl_q[CTRL_HOLD_BIT];
	assign healthy = inverter_on && !fault_present;
	assign cap_ok = count_q < activations_per_day_q;
	assign start_ok = en && !cfg_wr && ev.above_act && healthy && cap_ok;
	assign duty = (run_time_minutes_q < HP_DUTY_MIN) ? HP_DUTY_MIN : run_time_minutes_q;
	assign qual_target = (mode == MODE_HEAT) ? hp_persist_q : qualify_or_holdover_minutes_q;

	// activation sequencer
	always_comb begin
		state_d = state_q;
		min_d = min_q;
		act_evt = 1'b0;
		if (!en || cfg_wr || mode == MODE_OFF) begin
			state_d = S_IDLE;
			min_d = '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					min_d = '0;
					if (start_ok && mode == MODE_HYST) begin
						state_d = S_ON;
						act_evt = 1'b1;
					end else if (start_ok) begin
						state_d = S_QUAL;
					end
				end
				S_QUAL: begin
					if (!ev.above_act || !healthy) begin
						state_d = S_IDLE;
						min_d = '0;
					end else if (ev.tick_min) begin
						if (min_q + 11'h001 >= qual_target) begin
							state_d = cap_ok ? ((mode == MODE_HEAT) ? S_ON : S_RUN) : S_IDLE;
							act_evt = cap_ok;
							min_d = '0;
						end else begin
							min_d = min_q + 11'h001;
						end
					end
				end
				S_RUN: begin
					if (!inverter_on) begin
						state_d = S_PAUSE;
					end else if (ev.tick_min) begin
						if (min_q + 11'h001 >= run_time_minutes_q) begin
							state_d = S_IDLE;
							min_d = '0;
						end else begin
							min_d = min_q + 11'h001;
						end
					end
				end
				S_PAUSE: begin
					if (dark_q >= DARK_MINUTES) begin
						state_d = S_IDLE;
						min_d = '0;
					end else if (inverter_on) begin
						state_d = S_RUN;
					end
				end
				S_ON: begin
					if (mode == MODE_HEAT) begin
						if (min_q >= duty && off_q >= hp_persist_q) begin
							state_d = S_IDLE;
							min_d = '0;
						end else if (ev.tick_min && min_q < duty) begin
							min_d = min_q + 11'h001;
						end
					end else if (ev.below_deact || !healthy) begin
						state_d = hold_en ? S_HOLD : S_IDLE;
						min_d = '0;
					end
				end
				S_HOLD: begin
					if (!ev.below_deact && healthy) begin
						state_d = S_ON;
						min_d = '0;
					end else if (ev.tick_min) begin
						if (min_q + 11'h001 >= qualify_or_holdover_minutes_q) begin
							state_d = S_IDLE;
							min_d = '0;
						end else begin
							min_d = min_q + 11'h001;
						end
					end
				end
				default: begin
					state_d = S_IDLE;
					min_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			min_q <= '0;
		end else begin
			state_q <= state_d;
			min_q <= min_d;
		end
	end

	// heat-pump deactivation persistence in minutes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			off_q <= '0;
		end else if (state_q != S_ON || !ev.below_deact) begin
			off_q <= '0;
		end else if (ev.tick_min && off_q != RUN_MAX) begin
			off_q <= off_q + 11'h001;
		end
	end

	// minutes without produced current
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dark_q <= '0;
		end else if (current_flowing) begin
			dark_q <= '0;
		end else if (ev.tick_min && dark_q < DARK_MINUTES) begin
			dark_q <= dark_q + 11'h001;
		end
	end

	// daily activation count; an activation in the boundary cycle counts for the new day
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else if (act_evt) begin
			count_q <= ev.tick_day ? 8'h01 : count_q + 8'h01;
		end else if (ev.tick_day) begin
			count_q <= '0;
		end
	end

	// contact polarity and heat-pump state outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			contact_q <= 1'b0;
			hp_q <= HP_NORMAL;
		end else begin
			contact_q <= (state_q == S_RUN || state_q == S_ON || state_q == S_HOLD) ^ nc;
			hp_q <= (mode == MODE_HEAT && state_q == S_ON) ? HP_BOOST : HP_NORMAL;
		end
	end

	assign switched_output_one = contact_q;
	assign hp_state = hp_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_run_done;
		state_q == S_RUN && inverter_on && en && !cfg_wr && ev.tick_min
			&& min_q + 11'h001 >= run_time_minutes_q;
	endsequence

	sequence s_rearm;
		state_q == S_IDLE && start_ok && mode == MODE_TIMED;
	endsequence

	run_end_a: assert property (s_run_done |=> state_q == S_IDLE)
		else $error("timed run did not end at its run time");
	rearm_a: assert property (s_run_done ##1 s_rearm |=> state_q == S_QUAL)
		else $error("qualification not re-armed after interval");
	qual_len_a: assert property (state_q == S_QUAL && mode == MODE_TIMED
		|-> min_q < qualify_or_holdover_minutes_q)
		else $error("qualification counter passed its period");
	qual_restart_a: assert property (state_q == S_QUAL && !ev.above_act
		|=> state_q == S_IDLE && min_q == '0)
		else $error("qualification not restarted on low power");
	shutoff_a: assert property (state_q == S_RUN && !inverter_on && en && !cfg_wr && mode != MODE_OFF
		|=> state_q == S_PAUSE ##1 switched_output_one == nc)
		else $error("output not released on inverter shutoff");
	dark_abandon_a: assert property (state_q == S_PAUSE && dark_q >= DARK_MINUTES
		|=> state_q == S_IDLE)
		else $error("run not abandoned after dark period");
	day_cap_a: assert property (act_evt |-> count_q < activations_per_day_q)
		else $error("activation beyond daily allowance");
	hyst_on_a: assert property (state_q == S_IDLE && mode == MODE_HYST && start_ok
		|=> state_q == S_ON ##1 switched_output_one != nc)
		else $error("hysteresis activation did not close contact");
	hyst_off_a: assert property (state_q == S_ON && mode == MODE_HYST && en && !cfg_wr
		&& ev.below_deact && !hold_en |=> state_q == S_IDLE)
		else $error("hysteresis deactivation missed");
	hold_keep_a: assert property (state_q == S_HOLD && en && !cfg_wr && mode != MODE_OFF
		&& !ev.below_deact && healthy |=> state_q == S_ON)
		else $error("short fault interrupted the output");
	hold_delay_a: assert property (state_q == S_ON && mode == MODE_HYST && en && !cfg_wr
		&& hold_en && !healthy |=> state_q == S_HOLD)
		else $error("hold-over delay not entered");
	hp_duty_a: assert property (state_q == S_ON && mode == MODE_HEAT && en && !cfg_wr
		&& min_q < duty |=> state_q == S_ON)
		else $error("heat-pump output ended before minimum duty");
	duty_floor_a: assert property (state_q == S_ON && mode == MODE_HEAT && en && !cfg_wr
		&& state_d == S_IDLE |-> min_q >= HP_DUTY_MIN)
		else $error("heat-pump output ended before ten minutes");
	hp_state_a: assert property (hp_state == HP_NORMAL || hp_state == HP_BOOST)
		else $error("heat-pump state outside 2 and 3");
	polarity_a: assert property ((state_q == S_IDLE && $stable(ctrl_q)) [*2]
		|-> switched_output_one == nc)
		else $error("idle contact does not follow polarity");
	day_clear_a: assert property (ev.tick_day && !act_evt |=> count_q == '0)
		else $error("daily counter not cleared at day boundary");
endmodule

// *** verif/epso_load_model.sv ***
// far-side load: sees the contact and counts how often it closes
module epso_load_model (
	input wire logic aclk,
	input wire logic contact,
	output int closures
);
	timeunit 1ns;
	timeprecision 1ps;
	bit last_q;
	// a closing edge is one start of the consumer; sampled mid-cycle, where settled
	always @(negedge aclk) begin
		if (contact && !last_q) closures <= closures + 1;
		last_q <= contact;
	end
endmodule

// *** verif/epso_top_test.sv ***
module epso_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import epso_pkg::*;
	logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
	logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
	logic s_axil_rready, inverter_on, fault_present, current_flowing, switched_output_one;
	logic [AW-1:0] s_axil_awaddr, s_axil_araddr;
	logic [31:0] s_axil_wdata, s_axil_rdata;
	logic [3:0] s_axil_wstrb;
	logic [1:0] s_axil_bresp, s_axil_rresp, hp_state;
	logic [PW-1:0] grid_excess_w, pv_power_w;
	int fails, samples_checked, closures, n0;
	logic [AW-1:0] ea[6] = '{OFS_ACT, OFS_ACT, OFS_T1, OFS_T1, OFS_T2, 8'h20};
	logic [31:0] ed[6] = '{32'h0, 32'h000F_3E59, 32'h0, 32'h0000_02D1, 32'h0000_05A1, 32'h1};
	epso_top #(.CYC_PER_MIN(20)) dut (.*);
	epso_load_model load (.aclk(aclk), .contact(switched_output_one), .closures(closures));
	// 25 MHz clock
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok, b_ok;
		logic [1:0] r;
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1;
		s_axil_wvalid <= 1;
		s_axil_bready <= 1;
		do begin
			@(negedge aclk);
			aw_ok = s_axil_awvalid && s_axil_awready;
			w_ok = s_axil_wvalid && s_axil_wready;
			b_ok = s_axil_bvalid;
			r = s_axil_bresp;
			@(posedge aclk);
			if (aw_ok) s_axil_awvalid <= 0;
			if (w_ok) s_axil_wvalid <= 0;
		end while (!b_ok);
		chk(r, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ok;
		logic [31:0] d;
		logic [1:0] r;
		s_axil_araddr <= a;
		s_axil_arvalid <= 1;
		s_axil_rready <= 1;
		do begin
			@(negedge aclk);
			ok = s_axil_rvalid;
			d = s_axil_rdata;
			r = s_axil_rresp;
			@(posedge aclk);
			if (s_axil_arready) s_axil_arvalid <= 0;
		end while (!ok);
		chk(d, e);
		chk(r, er);
	endtask
	// contact must reach v after lo..hi cycles
	task automatic wo(input logic v, input int lo, input int hi);
		int n;
		for (n = 0; n <= hi; n++) begin
			@(negedge aclk);
			if (switched_output_one === v) break;
			@(posedge aclk);
		end
		@(posedge aclk);
		chk(n >= lo && n <= hi, 1);
	endtask
	// contact must stay at v for n cycles
	task automatic hold(input logic v, input int n);
		logic ok;
		ok = 1;
		repeat (n) begin
			@(negedge aclk);
			ok &= (switched_output_one === v);
			@(posedge aclk);
		end
		chk(ok, 1);
	endtask
	task automatic report_and_stop;
		if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#(40 * 40000);
		fails++;
		report_and_stop;
	end
	// main sequence
	initial begin
		{aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid} = 0;
		{s_axil_rready, fault_present, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 0;
		{grid_excess_w, pv_power_w} = 0;
		{inverter_on, current_flowing, s_axil_wstrb} = 6'h3F;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(OFS_STAT, 32'h0000_0008, RESP_OKAY);
		rd(OFS_ACT, 32'h0000_03E8, RESP_OKAY);
		for (int i = 0; i < 6; i++) wr(ea[i], ed[i], RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		// timed activation, two a day
		wr(OFS_T1, 32'h2, RESP_OKAY);
		wr(OFS_T2, 32'h2, RESP_OKAY);
		wr(OFS_TA, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		n0 = closures;
		grid_excess_w <= 20'h0_05DC;
		wo(1, 18, 46);
		wo(0, 18, 46);
		wo(1, 18, 46);
		inverter_on <= 0;
		wo(0, 0, 5);
		inverter_on <= 1;
		wo(1, 0, 5);
		wo(0, 0, 46);
		hold(0, 80);
		chk(closures - n0, 3);
		// hysteresis on grid excess, then pv, then normally closed
		wr(OFS_TA, 32'hA, RESP_OKAY);
		wr(OFS_CTRL, 32'h5, RESP_OKAY);
		grid_excess_w <= 20'h0_03E8;
		wo(1, 0, 5);
		grid_excess_w <= 20'h0_02BC;
		hold(1, 10);
		grid_excess_w <= 20'h0_02BB;
		wo(0, 0, 5);
		wr(OFS_CTRL, 32'hD, RESP_OKAY);
		pv_power_w <= 20'h0_05DC;
		wo(1, 0, 5);
		wr(OFS_CTRL, 32'h1D, RESP_OKAY);
		wo(0, 0, 5);
		pv_power_w <= 0;
		wo(1, 0, 5);
		// hold-over over a short and a long fault
		wr(OFS_CTRL, 32'h25, RESP_OKAY);
		grid_excess_w <= 20'h0_05DC;
		wo(1, 0, 5);
		fault_present <= 1;
		hold(1, 15);
		fault_present <= 0;
		hold(1, 50);
		fault_present <= 1;
		wo(0, 18, 46);
		fault_present <= 0;
		grid_excess_w <= 0;
		// heat-pump recommendation
		wr(OFS_CTRL, 32'h7, RESP_OKAY);
		wr(OFS_T2, 32'h5, RESP_SLVERR);
		wr(OFS_T2, 32'hA, RESP_OKAY);
		wr(OFS_HPQ, 32'h1, RESP_OKAY);
		grid_excess_w <= 20'h0_05DC;
		wo(1, 0, 26);
		chk(hp_state, HP_BOOST);
		grid_excess_w <= 0;
		wo(0, 180, 250);
		chk(hp_state, HP_NORMAL);
		// dark period abandons a paused run, then the day boundary clears the count
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		grid_excess_w <= 20'h0_05DC;
		wo(1, 18, 46);
		{inverter_on, current_flowing} <= 2'b00;
		wo(0, 0, 5);
		hold(0, 3700);
		grid_excess_w <= 0;
		{inverter_on, current_flowing} <= 2'b11;
		hold(0, 30);
		hold(0, 25000);
		rd(OFS_STAT, 32'h0000_0008, RESP_OKAY);
		report_and_stop;
	end
endmodule
